// [core/ccw_exec.sv]
// execution logic for clear-file, watchdog-clear and complement-file
// assumes AXI4-Lite master; instruction issued by writing the instruction register
//
// Behaviour
// - complement reads the addressed file register and yields its bitwise inverse.
// - with destination bit 0 the inverse goes to the working register, file untouched.
// - with destination bit 1 the inverse is written back to the same file register.
// - with access bit 0 the 8-bit address resolves inside the access bank.
// - with access bit 1 the bank select register picks the bank and the 8-bit address the register in it.
// - extended set on, access bit 0 and address up to 95 use indexed literal offset.
// - complement is a 16-bit word with top bits 000111, then d, a and 8-bit address.
// - watchdog clear zeroes counter and postscaler and sets timeout and power-down flags.
// - clear-file writes zero to the addressed register and sets the zero flag.
`timescale 1ns/1ps
module ccw_exec
  import ccw_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              clockEnable,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              arready;
    logic              awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic              wHeld;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              extEnable;
    logic [3:0]        bankSelect;
    logic [FILE_W-1:0] indexBase;
    logic [FILE_W-1:0] memAddr;
    logic [7:0]        wreg;
    logic              zeroFlag;
    logic              negFlag;
    logic              timeoutFlag;
    logic              powerdownFlag;
    logic [7:0]        wdtCount;
    logic [7:0]        wdtPost;
    ccw_phase_t        phase;
    logic [15:0]       instr;
    ccw_op_t           opKind;
    logic              dBit;
    logic              aBit;
    logic [7:0]        fAddr;
    logic [FILE_W-1:0] effAddr;
    logic [7:0]        operand;
    logic [7:0]        result;
  } ccw_state_t;

  ccw_state_t st;
  ccw_state_t next_st;

  logic [7:0]        fileMem [0:FILE_DEPTH-1];
  logic              memWe;
  logic [FILE_W-1:0] memWa;
  logic [7:0]        memWd;
  logic [7:0]        memRdSw;
  logic [7:0]        memRdOp;
  logic              wrOk;
  logic [31:0]       wrOld;
  logic [31:0]       wrVal;
  logic [31:0]       rdVal;
  logic              rdOk;

  assign memRdSw = fileMem[st.memAddr];
  assign memRdOp = fileMem[st.effAddr];

  function automatic logic [31:0] regValue(input logic [ADDR_W-1:0] a, output logic ok);
    logic [31:0] v;
    v = 32'h0000_0000;
    ok = 1'b1;
    unique case ({a[ADDR_W-1:2], 2'b00})
      OFF_INSTR:   v[15:0] = st.instr;
      OFF_CTRL:    begin
        v[CTRL_EXT_BIT] = st.extEnable;
        v[CTRL_BSR_LO +: 4] = st.bankSelect;
      end
      OFF_WREG:    v[7:0] = st.wreg;
      OFF_STATUS:  begin
        v[ST_ZERO_BIT] = st.zeroFlag;
        v[ST_NEG_BIT]  = st.negFlag;
        v[ST_TO_BIT]   = st.timeoutFlag;
        v[ST_PD_BIT]   = st.powerdownFlag;
        v[ST_BUSY_BIT] = (st.phase != PH_IDLE);
      end
      OFF_INDEX:   v[FILE_W-1:0] = st.indexBase;
      OFF_MEMADDR: v[FILE_W-1:0] = st.memAddr;
      OFF_MEMDATA: v[7:0] = memRdSw;
      OFF_WDOG:    begin
        v[7:0] = st.wdtCount;
        v[WD_POST_LO +: 8] = st.wdtPost;
      end
      default:     ok = 1'b0;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    memWe = 1'b0;
    memWa = st.effAddr;
    memWd = 8'h00;
    wrOk = 1'b0;
    wrOld = 32'h0000_0000;
    wrVal = 32'h0000_0000;
    rdVal = 32'h0000_0000;
    rdOk = 1'b0;
    if (clockEnable) begin
      // watchdog runs freely; a clear below overrides the increment
      {next_st.wdtPost, next_st.wdtCount} = 16'({st.wdtPost, st.wdtCount} + 16'h0001);

      // bus side: address and data are taken independently
      if (st.bvalid && bready)
        next_st.bvalid = 1'b0;
      if (awvalid && st.awready) begin
        next_st.awHeld = 1'b1;
        next_st.awAddr = awaddr;
      end
      if (wvalid && st.wready) begin
        next_st.wHeld = 1'b1;
        next_st.wData = wdata;
        next_st.wStrb = wstrb;
      end
      // the file port belongs to write-back in the fourth phase, so a bus write waits
      if (st.awHeld && st.wHeld && !st.bvalid && st.phase != PH_Q4) begin
        wrOld = regValue(st.awAddr, wrOk);
        for (int i = 0; i < 4; i++)
          wrVal[i*8 +: 8] = st.wStrb[i] ? st.wData[i*8 +: 8] : wrOld[i*8 +: 8];
        next_st.awHeld = 1'b0;
        next_st.wHeld = 1'b0;
        next_st.bvalid = 1'b1;
        next_st.bresp = wrOk ? RESP_OKAY : RESP_DECERR;
        unique case ({st.awAddr[ADDR_W-1:2], 2'b00})
          OFF_INSTR:   if (st.phase == PH_IDLE) begin
            // an issue while busy is dropped, not queued
            next_st.instr = wrVal[15:0];
            next_st.phase = PH_Q1;
          end
          OFF_CTRL:    begin
            next_st.extEnable = wrVal[CTRL_EXT_BIT];
            next_st.bankSelect = wrVal[CTRL_BSR_LO +: 4];
          end
          OFF_WREG:    next_st.wreg = wrVal[7:0];
          OFF_STATUS:  begin
            next_st.zeroFlag = wrVal[ST_ZERO_BIT];
            next_st.negFlag = wrVal[ST_NEG_BIT];
            next_st.timeoutFlag = wrVal[ST_TO_BIT];
            next_st.powerdownFlag = wrVal[ST_PD_BIT];
          end
          OFF_INDEX:   next_st.indexBase = wrVal[FILE_W-1:0];
          OFF_MEMADDR: next_st.memAddr = wrVal[FILE_W-1:0];
          OFF_MEMDATA: begin
            memWe = 1'b1;
            memWa = st.memAddr;
            memWd = wrVal[7:0];
          end
          default:     ;
        endcase
      end
      if (st.rvalid && rready)
        next_st.rvalid = 1'b0;
      if (arvalid && st.arready) begin
        rdVal = regValue(araddr, rdOk);
        next_st.rvalid = 1'b1;
        next_st.rdata = rdVal;
        next_st.rresp = rdOk ? RESP_OKAY : RESP_DECERR;
      end

      // instruction phases; their flag updates come after bus writes and win
      unique case (st.phase)
        PH_IDLE: ;
        PH_Q1:   begin
          next_st.dBit = st.instr[D_BIT];
          next_st.aBit = st.instr[A_BIT];
          next_st.fAddr = st.instr[7:0];
          if (st.instr[15:10] == COMP_TOP)
            next_st.opKind = OP_COMP;
          else if (st.instr[15:9] == CLR_TOP)
            next_st.opKind = OP_CLR;
          else if (st.instr == WDT_WORD)
            next_st.opKind = OP_WDT;
          else
            next_st.opKind = OP_NONE;
          if (st.instr[A_BIT])
            next_st.effAddr = {st.bankSelect, st.instr[7:0]};
          else if (st.extEnable && st.instr[7:0] <= INDEX_MAX)
            next_st.effAddr = FILE_W'(st.indexBase + {4'h0, st.instr[7:0]});
          else if (st.instr[7:0] <= INDEX_MAX)
            next_st.effAddr = {ACC_LO_BNK, st.instr[7:0]};
          else
            next_st.effAddr = {ACC_HI_BNK, st.instr[7:0]};
          next_st.phase = PH_Q2;
        end
        PH_Q2:   begin
          next_st.operand = memRdOp;
          next_st.phase = PH_Q3;
        end
        PH_Q3:   begin
          next_st.result = (st.opKind == OP_COMP) ? ~st.operand : 8'h00;
          if (st.opKind == OP_WDT) begin
            next_st.wdtCount = 8'h00;
            next_st.wdtPost = 8'h00;
            next_st.timeoutFlag = 1'b1;
            next_st.powerdownFlag = 1'b1;
          end
          next_st.phase = PH_Q4;
        end
        PH_Q4:   begin
          if (st.opKind == OP_CLR) begin
            memWe = 1'b1;
            memWd = 8'h00;
            next_st.zeroFlag = 1'b1;
          end
          if (st.opKind == OP_COMP) begin
            if (st.dBit) begin
              memWe = 1'b1;
              memWd = st.result;
            end else begin
              next_st.wreg = st.result;
            end
            next_st.negFlag = st.result[7];
            next_st.zeroFlag = (st.result == 8'h00);
          end
          next_st.phase = PH_IDLE;
        end
      endcase

      next_st.awready = !next_st.awHeld && !next_st.bvalid;
      next_st.wready = !next_st.wHeld && !next_st.bvalid;
      next_st.arready = !next_st.rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.timeoutFlag <= 1'b1;
      st.powerdownFlag <= 1'b1;
      st.phase <= PH_IDLE;
      st.opKind <= OP_NONE;
    end else begin
      st <= next_st;
    end
  end

  // file memory has no reset; contents are undefined until written
  always_ff @(posedge clock) begin
    if (memWe)
      fileMem[memWa] <= memWd;
  end

  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset || !clockEnable);

  comp_invert_a: assert property (st.phase == PH_Q3 && st.opKind == OP_COMP |=>
    st.result == ~$past(st.operand)) else $error("complement result is not the inverse");
  comp_to_w_a: assert property (st.phase == PH_Q4 && st.opKind == OP_COMP && !st.dBit |->
    !memWe ##1 st.wreg == $past(st.result)) else $error("complement to w misrouted");
  comp_to_f_a: assert property (st.phase == PH_Q4 && st.opKind == OP_COMP && st.dBit |->
    memWe && memWa == st.effAddr && memWd == st.result) else $error("complement write-back wrong");
  // decode used the control values of the Q1 cycle; a bus write may change them at that edge
  access_bank_a: assert property (st.phase == PH_Q2 && !st.aBit &&
    !($past(st.extEnable) && st.fAddr <= INDEX_MAX) |-> st.effAddr ==
    {(st.fAddr <= INDEX_MAX) ? ACC_LO_BNK : ACC_HI_BNK, st.fAddr})
    else $error("access bank address wrong");
  banked_addr_a: assert property (st.phase == PH_Q2 && st.aBit |->
    st.effAddr == {$past(st.bankSelect), st.fAddr}) else $error("banked address wrong");
  indexed_addr_a: assert property (st.phase == PH_Q2 && !st.aBit && $past(st.extEnable) &&
    st.fAddr <= INDEX_MAX |-> st.effAddr == FILE_W'($past(st.indexBase) + {4'h0, st.fAddr}))
    else $error("indexed address wrong");
  comp_decode_a: assert property (st.phase == PH_Q1 && st.instr[15:10] == COMP_TOP |=>
    st.opKind == OP_COMP) else $error("complement not decoded");
  wdt_clear_a: assert property (st.phase == PH_Q3 && st.opKind == OP_WDT |=>
    st.wdtCount == 8'h00 && st.wdtPost == 8'h00 && st.timeoutFlag && st.powerdownFlag)
    else $error("watchdog clear incomplete");
  clear_file_a: assert property (st.phase == PH_Q4 && st.opKind == OP_CLR |->
    memWe && memWd == 8'h00 && memWa == st.effAddr ##1 st.zeroFlag)
    else $error("clear file wrong");
  comp_flags_a: assert property (st.phase == PH_Q4 && st.opKind == OP_COMP |=>
    st.negFlag == $past(st.result[7]) && st.zeroFlag == ($past(st.result) == 8'h00) &&
    $stable(st.timeoutFlag)) else $error("complement flags wrong");
  four_phase_a: assert property (st.phase == PH_Q1 |=> st.phase == PH_Q2 ##1
    st.phase == PH_Q3 ##1 st.phase == PH_Q4 ##1 st.phase == PH_IDLE)
    else $error("phase sequence broken");

  comp_w_c: cover property (st.phase == PH_Q4 && st.opKind == OP_COMP && !st.dBit);
  comp_f_c: cover property (st.phase == PH_Q4 && st.opKind == OP_COMP && st.dBit);
  wdt_c:    cover property (st.phase == PH_Q3 && st.opKind == OP_WDT);
  clr_c:    cover property (st.phase == PH_Q4 && st.opKind == OP_CLR && !st.aBit);

endmodule

// [core/ccw_pkg.sv]
// package for the clear / complement / watchdog-clear execution block
// assumes a 32-bit AXI4-Lite register bus and one core clock
package ccw_pkg;

  localparam int ADDR_W = 8;
  localparam int FILE_W = 12;
  localparam int FILE_DEPTH = 4096;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_INSTR   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_WREG    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_INDEX   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MEMADDR = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MEMDATA = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_WDOG    = 8'h1C;

  // field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_BSR_LO  = 8;
  localparam int ST_ZERO_BIT  = 0;
  localparam int ST_NEG_BIT   = 1;
  localparam int ST_TO_BIT    = 2;
  localparam int ST_PD_BIT    = 3;
  localparam int ST_BUSY_BIT  = 4;
  localparam int WD_POST_LO   = 8;

  // instruction encoding
  localparam logic [5:0]  COMP_TOP   = 6'h07;
  localparam logic [6:0]  CLR_TOP    = 7'h35;
  localparam logic [15:0] WDT_WORD   = 16'h0004;
  localparam int          D_BIT      = 9;
  localparam int          A_BIT      = 8;
  localparam logic [7:0]  INDEX_MAX  = 8'h5F;
  localparam logic [3:0]  ACC_LO_BNK = 4'h0;
  localparam logic [3:0]  ACC_HI_BNK = 4'hF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} ccw_phase_t;
  typedef enum logic [1:0] {OP_NONE, OP_CLR, OP_WDT, OP_COMP} ccw_op_t;

endpackage

// [sim/clear_complement_watchdog_ops_test.sv]
// self-checking bench for the clear / complement / watchdog-clear block
// assumes the block is reached only through its AXI4-Lite slave port
`timescale 1ns/1ps
module clear_complement_watchdog_ops_test;
  import ccw_pkg::*;

  logic              clock = 1'b0;
  logic              reset;
  logic              clockEnable;
  logic [ADDR_W-1:0] awaddr;
  logic              awvalid;
  logic              awready;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wvalid;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready;
  logic [ADDR_W-1:0] araddr;
  logic              arvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready;
  logic [31:0]       seenData;
  logic [1:0]        seenResp;
  logic [15:0]       firstCount;
  int                bad_count = 0;
  int                samples_checked = 0;

  always #12.5 clock = ~clock;

  ccw_exec dut_u (
    .clock(clock), .reset(reset), .clockEnable(clockEnable),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_up(input string what);
    bad_count++;
    $display("MISMATCH t=%0t no answer on %s", $time, what);
    report_and_stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // each task starts one edge late so a valid dropped at the last edge is not re-driven
  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    int n;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 40) give_up("write");
  endtask

  task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    int n;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 40) give_up("read");
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus_write(a, d, seenResp);
    check(32'(seenResp), 32'(RESP_OKAY), "write response");
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
    bus_read(a, seenData, seenResp);
    check(seenData, exp, what);
  endtask

  task automatic set_mem(input logic [11:0] a, input logic [7:0] d);
    wr(OFF_MEMADDR, 32'(a));
    wr(OFF_MEMDATA, 32'(d));
  endtask

  // busy must still show right after issue; four phases leave it clear soon after
  task automatic run(input logic [15:0] word);
    int n;
    wr(OFF_INSTR, 32'(word));
    bus_read(OFF_STATUS, seenData, seenResp);
    check(32'(seenData[ST_BUSY_BIT]), 32'h1, "busy after issue");
    for (n = 0; n < 4; n++) begin
      bus_read(OFF_STATUS, seenData, seenResp);
      if (seenData[ST_BUSY_BIT] === 1'b0) break;
    end
    if (n == 4) give_up("busy clear");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset       = 1'b1;
    clockEnable = 1'b1;
    awaddr      = 8'h00;
    awvalid     = 1'b0;
    wdata       = 32'h0;
    wstrb       = 4'hF;
    wvalid      = 1'b0;
    bready      = 1'b0;
    araddr      = 8'h00;
    arvalid     = 1'b0;
    rready      = 1'b0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rd(OFF_STATUS, 32'h0000000C, "status after reset");
    bus_read(8'h20, seenData, seenResp);
    check(32'(seenResp), 32'(RESP_DECERR), "unmapped read");
    bus_write(8'h24, 32'h5, seenResp);
    check(32'(seenResp), 32'(RESP_DECERR), "unmapped write");
    $display("test reset_map done");
    // complement into the working register through bank 3
    wr(OFF_CTRL, 32'h00000300);
    set_mem(12'h345, 8'h13);
    run(16'h1D45);
    rd(OFF_WREG, 32'h000000EC, "complement to wreg");
    rd(OFF_MEMDATA, 32'h00000013, "file untouched");
    rd(OFF_STATUS, 32'h0000000E, "negative set");
    // complement back into the file, result zero
    set_mem(12'h345, 8'hFF);
    run(16'h1F45);
    rd(OFF_MEMDATA, 32'h00000000, "complement written back");
    rd(OFF_WREG, 32'h000000EC, "wreg untouched");
    rd(OFF_STATUS, 32'h0000000D, "zero set negative clear");
    $display("test complement done");
    // clear through the access bank high half, then banked
    wr(OFF_STATUS, 32'h0000000E);
    set_mem(12'h380, 8'h77);
    set_mem(12'hF80, 8'h5A);
    run(16'h6A80);
    rd(OFF_MEMDATA, 32'h00000000, "access bank cleared");
    rd(OFF_STATUS, 32'h0000000F, "zero set negative kept");
    wr(OFF_MEMADDR, 32'h00000380);
    rd(OFF_MEMDATA, 32'h00000077, "banked copy kept");
    run(16'h6B80);
    rd(OFF_MEMDATA, 32'h00000000, "banked clear");
    $display("test clear done");
    // indexed offset at the boundary address and just above it
    wr(OFF_CTRL, 32'h00000301);
    wr(OFF_INDEX, 32'h00000200);
    set_mem(12'hF60, 8'h3C);
    set_mem(12'h25F, 8'hA5);
    run(16'h1E5F);
    rd(OFF_MEMDATA, 32'h0000005A, "indexed complement");
    run(16'h6A60);
    wr(OFF_MEMADDR, 32'h00000F60);
    rd(OFF_MEMDATA, 32'h00000000, "above limit uses access bank");
    // only byte lane 1 is written; the enable bit in lane 0 must survive
    wstrb <= 4'h2;
    wr(OFF_CTRL, 32'h00000F00);
    wstrb <= 4'hF;
    rd(OFF_CTRL, 32'h00000F01, "byte lane merge");
    $display("test indexed done");
    // watchdog clear restarts the count and raises both flags
    wr(OFF_STATUS, 32'h00000000);
    run(16'h0004);
    bus_read(OFF_WDOG, seenData, seenResp);
    check(32'(seenData[31:6]), 32'h0, "watchdog restarted");
    rd(OFF_STATUS, 32'h0000000C, "timeout and powerdown set");
    $display("test watchdog done");
    // with enable low the count holds; only the three enabled edges of the bus gap count
    bus_read(OFF_WDOG, seenData, seenResp);
    firstCount = seenData[15:0];
    clockEnable <= 1'b0;
    repeat (10) @(posedge clock);
    clockEnable <= 1'b1;
    bus_read(OFF_WDOG, seenData, seenResp);
    check(32'(16'(seenData[15:0] - firstCount)), 32'h3, "count frozen while disabled");
    $display("test enable done");
    report_and_stop();
  end

endmodule
